// *** rtl/irqsrc_top.v ***
/*
  Interrupt source logic: reset cause register, three external edge
  interrupts, timer zero overflow, port change detect, priority routing
  and context save on interrupt entry, behind a classic Wishbone slave.
  Assumes the core supplies the context values, the reset cause events and
  a take pulse when it vectors; pins are asynchronous.
*/
`include "irqsrc_regs.vh"
`default_nettype none

module irqsrc_top
(
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  input  wire [2:0]  extIrqPin,
  input  wire [7:0]  portBPin,
  input  wire [3:0]  portBIsInput,
  input  wire        sleeping,
  input  wire        resetInstrEvent,
  input  wire        wdtTimeoutEvent,
  input  wire        powerDownEvent,
  input  wire        powerDownClear,
  input  wire        irqTaken,
  input  wire [15:0] returnAddr,
  input  wire [7:0]  workingRegister,
  input  wire [7:0]  statusRegister,
  input  wire [7:0]  bankSelectRegister,
  output reg         irqHigh,
  output reg         irqLow,
  output reg         wakeUp,
  output reg         vectorAfterWake
);

  reg  [7:0]  resetCause_reg;
  reg  [7:0]  ctrlMain_reg;
  reg  [7:0]  ctrlSecond_reg;
  reg  [7:0]  ctrlThird_reg;
  reg  [1:0]  timerCfg_reg;
  reg  [3:0]  portLatch_reg;
  reg  [2:0]  extPrev_reg;
  reg  [23:0] shadow_reg;
  reg  [15:0] retStack_reg;
  reg         irqHigh_next;
  reg         irqLow_next;
  reg  [31:0] readData;
  reg  [2:0]  settle_reg;

  wire [6:0]  syncPins;
  wire [2:0]  extSync;
  wire [3:0]  portSync;
  wire [15:0] timerCount;
  wire        timerOverflow;
  wire        access;
  wire        wrStrobe;
  wire        rdStrobe;
  wire        wrLane0;
  wire [7:0]  wrByte;
  wire [2:0]  edgeSelect;
  wire [2:0]  extEdge;
  wire        portMismatch;
  wire        syncReady;
  wire        prioEn;
  wire        reqExt0;
  wire        reqExt1;
  wire        reqExt2;
  wire        reqTimer;
  wire        reqPort;

  function wrHit;
    input [7:0] addr;
    input [7:0] target;
    begin
      wrHit = wrLane0 && (addr == target);
    end
  endfunction

  irqsrc_pin_sync #(.WIDTH(7)) pinSync
  (
    .clk    (clk),
    .reset  (reset),
    .pinIn  ({portBPin[7:4], extIrqPin}),
    .pinOut (syncPins)
  );

  assign extSync  = syncPins[2:0];
  assign portSync = syncPins[6:3];

  // Bus slave: one wait state, ack one cycle
  assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStrobe = access & wb_we_i;
  assign rdStrobe = access & ~wb_we_i;
  assign wrLane0  = wrStrobe & wb_sel_i[0];
  assign wrByte   = wb_dat_i[7:0];

  irqsrc_timer timerZero
  (
    .clk      (clk),
    .reset    (reset),
    .run      (timerCfg_reg[`IRQSRC_TC_RUN]),
    .wideMode (timerCfg_reg[`IRQSRC_TC_WIDE]),
    .loadLow  (wrHit(wb_adr_i, `IRQSRC_ADDR_TIMER_LOW)),
    .loadHigh (wrHit(wb_adr_i, `IRQSRC_ADDR_TIMER_HIGH)),
    .loadData (wrByte),
    .count    (timerCount),
    .overflow (timerOverflow)
  );

  assign edgeSelect = {ctrlSecond_reg[`IRQSRC_S_EDGE2], ctrlSecond_reg[`IRQSRC_S_EDGE1],
                       ctrlSecond_reg[`IRQSRC_S_EDGE0]};

  // No false edge while the synchroniser fills after reset
  assign syncReady  = (settle_reg == `IRQSRC_SYNC_SETTLE);
  assign extEdge    = {3{syncReady}}
                    & ((edgeSelect & extSync & ~extPrev_reg)
                    | (~edgeSelect & ~extSync & extPrev_reg));

  assign portMismatch = |((portSync ^ portLatch_reg) & portBIsInput);

  always @(posedge clk)
  begin
    if (reset)
    begin
      extPrev_reg   <= 3'h0;
      portLatch_reg <= 4'h0;
      settle_reg    <= 3'h0;
    end
    else
    begin
      extPrev_reg <= extSync;
      // Settle counter
      if (!syncReady)
        settle_reg <= settle_reg + 3'h1;
      if (access && wb_adr_i == `IRQSRC_ADDR_PORT_B)
        portLatch_reg <= portSync;
    end
  end

  // Reset cause register
  always @(posedge clk)
  begin
    if (reset)
      resetCause_reg <= `IRQSRC_RC_RESET_VAL;
    else
    begin
      // Writable cause bits, read-only timeout and power-down
      if (wrHit(wb_adr_i, `IRQSRC_ADDR_RESET_CAUSE))
        resetCause_reg <= (resetCause_reg & ~`IRQSRC_RC_WRITE_MASK)
                        | (wrByte & `IRQSRC_RC_WRITE_MASK);
      // Hardware cause events win over writes
      if (resetInstrEvent)
        resetCause_reg[`IRQSRC_RC_RESET_INSTR] <= 1'b0;
      if (wdtTimeoutEvent)
        resetCause_reg[`IRQSRC_RC_WDT_TIMEOUT] <= 1'b0;
      if (powerDownEvent)
        resetCause_reg[`IRQSRC_RC_POWER_DOWN] <= 1'b0;
      else if (powerDownClear)
        resetCause_reg[`IRQSRC_RC_POWER_DOWN] <= 1'b1;
    end
  end

  // Control registers and flags
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrlMain_reg   <= 8'h00;
      ctrlSecond_reg <= `IRQSRC_S_RESET_VAL;
      ctrlThird_reg  <= `IRQSRC_T_RESET_VAL;
      timerCfg_reg   <= 2'h0;
    end
    else
    begin
      if (wrHit(wb_adr_i, `IRQSRC_ADDR_CTRL_MAIN))
        ctrlMain_reg <= wrByte;
      if (wrHit(wb_adr_i, `IRQSRC_ADDR_CTRL_SECOND))
        ctrlSecond_reg <= wrByte & 8'hF5;
      if (wrHit(wb_adr_i, `IRQSRC_ADDR_CTRL_THIRD))
        ctrlThird_reg <= wrByte & 8'hDB;
      if (wrHit(wb_adr_i, `IRQSRC_ADDR_TIMER_CFG))
        timerCfg_reg <= wrByte[1:0];
      // Flags set regardless of enable, set wins
      if (extEdge[0])
        ctrlMain_reg[`IRQSRC_M_EXT0_FLAG] <= 1'b1;
      if (extEdge[1])
        ctrlThird_reg[`IRQSRC_T_EXT1_FLAG] <= 1'b1;
      if (extEdge[2])
        ctrlThird_reg[`IRQSRC_T_EXT2_FLAG] <= 1'b1;
      if (timerOverflow)
        ctrlMain_reg[`IRQSRC_M_TIMER_FLAG] <= 1'b1;
      if (portMismatch)
        ctrlMain_reg[`IRQSRC_M_PORT_FLAG] <= 1'b1;
    end
  end

  assign prioEn = resetCause_reg[`IRQSRC_RC_PRIO_EN];

  assign reqExt0  = ctrlMain_reg[`IRQSRC_M_EXT0_FLAG] & ctrlMain_reg[`IRQSRC_M_EXT0_EN];
  assign reqExt1  = ctrlThird_reg[`IRQSRC_T_EXT1_FLAG] & ctrlThird_reg[`IRQSRC_T_EXT1_EN];
  assign reqExt2  = ctrlThird_reg[`IRQSRC_T_EXT2_FLAG] & ctrlThird_reg[`IRQSRC_T_EXT2_EN];
  assign reqTimer = ctrlMain_reg[`IRQSRC_M_TIMER_FLAG] & ctrlMain_reg[`IRQSRC_M_TIMER_EN];
  assign reqPort  = ctrlMain_reg[`IRQSRC_M_PORT_FLAG] & ctrlMain_reg[`IRQSRC_M_PORT_EN];

  // Priority routing
  always @*
  begin
    irqHigh_next = 1'b0;
    irqLow_next  = 1'b0;
    if (prioEn)
    begin
      irqHigh_next = reqExt0
                   | (reqExt1 & ctrlThird_reg[`IRQSRC_T_EXT1_PRIO])
                   | (reqExt2 & ctrlThird_reg[`IRQSRC_T_EXT2_PRIO])
                   | (reqTimer & ctrlSecond_reg[`IRQSRC_S_TIMER_PRIO])
                   | (reqPort & ctrlSecond_reg[`IRQSRC_S_PORT_PRIO]);
      irqLow_next  = (reqExt1 & ~ctrlThird_reg[`IRQSRC_T_EXT1_PRIO])
                   | (reqExt2 & ~ctrlThird_reg[`IRQSRC_T_EXT2_PRIO])
                   | (reqTimer & ~ctrlSecond_reg[`IRQSRC_S_TIMER_PRIO])
                   | (reqPort & ~ctrlSecond_reg[`IRQSRC_S_PORT_PRIO]);
      irqHigh_next = irqHigh_next & ctrlMain_reg[`IRQSRC_M_GLOBAL_EN];
      irqLow_next  = irqLow_next & ctrlMain_reg[`IRQSRC_M_PERIPH_EN];
    end
    else
    begin
      irqHigh_next = ctrlMain_reg[`IRQSRC_M_GLOBAL_EN]
                   & (reqExt0 | reqExt1 | reqExt2 | reqTimer | reqPort)
                   & ctrlMain_reg[`IRQSRC_M_PERIPH_EN];
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      irqHigh         <= 1'b0;
      irqLow          <= 1'b0;
      wakeUp          <= 1'b0;
      vectorAfterWake <= 1'b0;
      shadow_reg      <= 24'h000000;
      retStack_reg    <= 16'h0000;
    end
    else
    begin
      irqHigh <= irqHigh_next;
      irqLow  <= irqLow_next;
      wakeUp  <= sleeping & (reqExt0 | reqExt1 | reqExt2);
      // Vector after wake only with global enable
      vectorAfterWake <= sleeping & (reqExt0 | reqExt1 | reqExt2)
                       & ctrlMain_reg[`IRQSRC_M_GLOBAL_EN];
      if (irqTaken)
      begin
        retStack_reg <= returnAddr;
        shadow_reg   <= {bankSelectRegister, statusRegister, workingRegister};
      end
    end
  end

  // Read mux
  always @*
  begin
    readData = 32'h00000000;
    case (wb_adr_i)
      // Bits 6 and 5 read zero
      `IRQSRC_ADDR_RESET_CAUSE: readData[7:0] = resetCause_reg & 8'h9F;
      `IRQSRC_ADDR_CTRL_MAIN:   readData[7:0] = ctrlMain_reg;
      `IRQSRC_ADDR_CTRL_SECOND: readData[7:0] = ctrlSecond_reg;
      `IRQSRC_ADDR_CTRL_THIRD:  readData[7:0] = ctrlThird_reg;
      `IRQSRC_ADDR_TIMER_LOW:   readData[7:0] = timerCount[7:0];
      `IRQSRC_ADDR_TIMER_HIGH:  readData[7:0] = timerCount[15:8];
      `IRQSRC_ADDR_PORT_B:      readData[7:0] = {portSync, 4'h0};
      `IRQSRC_ADDR_TIMER_CFG:   readData[1:0] = timerCfg_reg;
      `IRQSRC_ADDR_SHADOW:      readData[23:0] = shadow_reg;
      `IRQSRC_ADDR_RET_ADDR:    readData[15:0] = retStack_reg;
      default:                  readData = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= access;
      if (rdStrobe)
        wb_dat_o <= readData;
    end
  end

endmodule // irqsrc_top

`default_nettype wire

// *** rtl/irqsrc_regs.vh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  interrupt source block. Assumes a 32-bit classic Wishbone slave, one word
  per register.
*/
`ifndef IRQSRC_REGS_VH
`define IRQSRC_REGS_VH

// Byte addresses
`define IRQSRC_ADDR_RESET_CAUSE 8'h00
`define IRQSRC_ADDR_CTRL_MAIN   8'h04
`define IRQSRC_ADDR_CTRL_SECOND 8'h08
`define IRQSRC_ADDR_CTRL_THIRD  8'h0C
`define IRQSRC_ADDR_TIMER_LOW   8'h10
`define IRQSRC_ADDR_TIMER_HIGH  8'h14
`define IRQSRC_ADDR_PORT_B      8'h18
`define IRQSRC_ADDR_TIMER_CFG   8'h1C
`define IRQSRC_ADDR_SHADOW      8'h20
`define IRQSRC_ADDR_RET_ADDR    8'h24

// Reset cause register fields
`define IRQSRC_RC_PRIO_EN     7
`define IRQSRC_RC_RESET_INSTR 4
`define IRQSRC_RC_WDT_TIMEOUT 3
`define IRQSRC_RC_POWER_DOWN  2
`define IRQSRC_RC_POWER_ON    1
`define IRQSRC_RC_BROWNOUT    0
`define IRQSRC_RC_RESET_VAL   8'h1C
`define IRQSRC_RC_WRITE_MASK  8'h93

// Main control register fields
`define IRQSRC_M_GLOBAL_EN   7
`define IRQSRC_M_PERIPH_EN   6
`define IRQSRC_M_TIMER_EN    5
`define IRQSRC_M_EXT0_EN     4
`define IRQSRC_M_PORT_EN     3
`define IRQSRC_M_TIMER_FLAG  2
`define IRQSRC_M_EXT0_FLAG   1
`define IRQSRC_M_PORT_FLAG   0

// Second control register fields
`define IRQSRC_S_EDGE0       6
`define IRQSRC_S_EDGE1       5
`define IRQSRC_S_EDGE2       4
`define IRQSRC_S_TIMER_PRIO  2
`define IRQSRC_S_PORT_PRIO   0
`define IRQSRC_S_RESET_VAL   8'h75

// Third control register fields
`define IRQSRC_T_EXT2_PRIO   7
`define IRQSRC_T_EXT1_PRIO   6
`define IRQSRC_T_EXT2_EN     4
`define IRQSRC_T_EXT1_EN     3
`define IRQSRC_T_EXT2_FLAG   1
`define IRQSRC_T_EXT1_FLAG   0
`define IRQSRC_T_RESET_VAL   8'hC0

// Timer config: bit 0 is 16-bit mode, bit 1 is run
`define IRQSRC_TC_WIDE       0
`define IRQSRC_TC_RUN        1

// Edges after reset until the pin synchroniser output is valid
`define IRQSRC_SYNC_SETTLE   3'h5

`endif

// *** rtl/irqsrc_pin_sync.v ***
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pin inputs; output changes once stages two and three agree.
*/
`default_nettype none

module irqsrc_pin_sync
#(
  parameter WIDTH = 7
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] stage1Reg;
  reg [WIDTH-1:0] stage2Reg;
  reg [WIDTH-1:0] stage3Reg;
  integer i;

  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1Reg <= {WIDTH{1'b0}};
      stage2Reg <= {WIDTH{1'b0}};
      stage3Reg <= {WIDTH{1'b0}};
      pinOut    <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      for (i = 0; i < WIDTH; i = i + 1)
        if (stage2Reg[i] == stage3Reg[i])
          pinOut[i] <= stage3Reg[i];
    end
  end

endmodule // irqsrc_pin_sync

`default_nettype wire

// *** rtl/irqsrc_timer.v ***
/*
  Timer zero counter with 8-bit and 16-bit modes and overflow pulse.
  Assumes software loads via write strobes from the register slave.
*/
`include "irqsrc_regs.vh"
`default_nettype none

module irqsrc_timer
(
  input  wire        clk,
  input  wire        reset,
  input  wire        run,
  input  wire        wideMode,
  input  wire        loadLow,
  input  wire        loadHigh,
  input  wire [7:0]  loadData,
  output reg  [15:0] count,
  output wire        overflow
);

  wire lowAllOnes;
  wire allOnes;

  assign lowAllOnes = (count[7:0] == 8'hFF);
  assign allOnes    = (count == 16'hFFFF);
  assign overflow   = run & ~loadLow & ~loadHigh & (wideMode ? allOnes : lowAllOnes);

  always @(posedge clk)
  begin
    if (reset)
      count <= 16'h0000;
    else if (loadLow)
      count[7:0] <= loadData;
    else if (loadHigh)
      count[15:8] <= loadData;
    else if (run)
    begin
      if (wideMode)
        count <= count + 16'h0001;
      else
        count[7:0] <= count[7:0] + 8'h01;
    end
  end

endmodule // irqsrc_timer

`default_nettype wire

// *** verification/irqsrc_props.sv ***
/*
  Port assertions for the interrupt source block.
  Assumes one clock, synchronous active-high reset, bound into irqsrc_top.
*/
`default_nettype none

module irqsrc_props
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        sleeping,
  input wire logic        irqTaken,
  input wire logic [15:0] returnAddr,
  input wire logic        irqHigh,
  input wire logic        irqLow,
  input wire logic        wakeUp,
  input wire logic        vectorAfterWake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] capRet;
  logic        capSeen;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Last return address handed over on a take
  always @(posedge clk)
  begin
    capSeen <= reset ? 1'h0 : (capSeen | irqTaken);
    capRet  <= irqTaken ? returnAddr : capRet;
  end
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_timing: assert property (wb_ack_o == $past(wb_cyc_i & wb_stb_i & !wb_ack_o))
    else $error("ack not one cycle after request");
  chk_cause_gap: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00) |-> wb_dat_o[6:5] == 2'h0)
    else $error("cause bits 6 and 5 not zero");
  chk_unmapped_zero: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h28) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_wake_vector: assert property (vectorAfterWake |-> wakeUp)
    else $error("vector after wake without wake");
  chk_wake_sleep: assert property (wakeUp |-> $past(sleeping))
    else $error("wake while not sleeping");
  chk_irq_reset: assert property ($fell(reset) |-> !irqHigh && !irqLow)
    else $error("request right after reset");
  chk_ret_addr: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h24 && capSeen && !$past(irqTaken))
    |-> wb_dat_o[15:0] == capRet)
    else $error("return address not saved");
  cov_high: cover property ($rose(irqHigh));
  cov_low: cover property ($rose(irqLow));
  cov_vector: cover property ($rose(vectorAfterWake));
endmodule // irqsrc_props

bind irqsrc_top irqsrc_props i_irqsrc_props (.clk(clk), .reset(reset), .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .sleeping(sleeping), .irqTaken(irqTaken), .returnAddr(returnAddr),
  .irqHigh(irqHigh), .irqLow(irqLow), .wakeUp(wakeUp), .vectorAfterWake(vectorAfterWake));

`default_nettype wire

// *** verification/irqsrc_core_model.sv ***
/*
  Behavioural core: takes each new request once and presents its context.
  Assumes request levels from the block and one clock.
*/
`default_nettype none

module irqsrc_core_model
#(
  parameter logic [15:0] RET  = 16'h2468,
  parameter logic [7:0]  WORK = 8'h5A,
  parameter logic [7:0]  STAT = 8'h3C,
  parameter logic [7:0]  BANK = 8'h0F
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        irqHigh,
  input  wire logic        irqLow,
  output logic             irqTaken,
  output logic [15:0]      returnAddr,
  output logic [7:0]       workingRegister,
  output logic [7:0]       statusRegister,
  output logic [7:0]       bankSelectRegister
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  assign returnAddr = RET;
  assign workingRegister = WORK;
  assign statusRegister = STAT;
  assign bankSelectRegister = BANK;
  always @(posedge clk)
  begin
    irqTaken <= !reset && (irqHigh | irqLow) && !busy;
    busy <= !reset && (irqHigh | irqLow);
  end
endmodule // irqsrc_core_model

`default_nettype wire

// *** verification/irq_sources_and_reset_flags_test.sv ***
/*
  Self-checking bench for the interrupt source block.
  Assumes a Wishbone master, a core model and pins driven here.
*/
`default_nettype none

module irq_sources_and_reset_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, reset = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0, sleeping = 1'h0;
  logic        evResetInstr = 1'h0, evWdt = 1'h0, evPowerDown = 1'h0, powerDownClr = 1'h0;
  logic [7:0]  adr = 8'h00, portPin = 8'h00, workReg, stat, bank;
  logic [31:0] datI = 32'h0, datO, q;
  logic [3:0]  sel = 4'h0, portIn = 4'hF;
  logic [2:0]  extPin = 3'h7;
  logic [15:0] ret;
  logic        ack, taken, irqHigh, irqLow, wakeUp, vecWake;
  int          miscompares = 0, comparisons = 0;

  irqsrc_top i_irqsrc_top (.clk(clk), .reset(reset), .wb_adr_i(adr), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .extIrqPin(extPin), .portBPin(portPin), .portBIsInput(portIn),
    .sleeping(sleeping), .resetInstrEvent(evResetInstr), .wdtTimeoutEvent(evWdt),
    .powerDownEvent(evPowerDown), .powerDownClear(powerDownClr), .irqTaken(taken),
    .returnAddr(ret),
    .workingRegister(workReg), .statusRegister(stat), .bankSelectRegister(bank),
    .irqHigh(irqHigh), .irqLow(irqLow), .wakeUp(wakeUp), .vectorAfterWake(vecWake));
  irqsrc_core_model i_irqsrc_core_model (.clk(clk), .reset(reset), .irqHigh(irqHigh),
    .irqLow(irqLow), .irqTaken(taken), .returnAddr(ret), .workingRegister(workReg),
    .statusRegister(stat), .bankSelectRegister(bank));

  task results;
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    we <= w;
    datI <= {24'h0, d};
    sel <= 4'hF;
    cyc <= 1'h1;
    stb <= 1'h1;
    n = 0;
    do @(posedge clk); while (ack !== 1'h1 && ++n < 20);
    q = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) check("ack", 32'h0, 32'h1);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'h1, d);
  endtask
  task rdChk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(a, 1'h0, 8'h00);
    check(nm, q, exp);
  endtask
  task settle;
    repeat (8) @(posedge clk);
  endtask
  task pins(input logic [2:0] v);
    @(posedge clk);
    extPin <= v;
    settle;
  endtask
  task req(input logic h, input logic l);
    check("irqHigh", 32'(irqHigh), 32'(h));
    check("irqLow", 32'(irqLow), 32'(l));
  endtask

  task testCause;
    rdChk(8'h00, 32'h1C, "cause");
    rdChk(8'h08, 32'h75, "second");
    rdChk(8'h0C, 32'hC0, "third");
    wr(8'h00, 8'hFF);
    rdChk(8'h00, 32'h9F, "cause");
    @(posedge clk);
    {evResetInstr, evWdt, evPowerDown} <= 3'h7;
    @(posedge clk);
    {evResetInstr, evWdt, evPowerDown} <= 3'h0;
    rdChk(8'h00, 32'h83, "cause");
    wr(8'h00, 8'hFF);
    rdChk(8'h00, 32'h93, "cause");
    @(posedge clk);
    powerDownClr <= 1'h1;
    @(posedge clk);
    powerDownClr <= 1'h0;
    rdChk(8'h00, 32'h97, "cause");
    wr(8'h3C, 8'hFF);
    rdChk(8'h3C, 32'h0, "unmapped");
  endtask
  task testEdges;
    wr(8'h18, 8'h00);
    for (int s = 1; s >= 0; s--)
    begin
      wr(8'h08, s ? 8'h75 : 8'h05);
      pins(s ? 3'h0 : 3'h7);
      wr(8'h04, 8'h00);
      wr(8'h0C, 8'hC0);
      pins(s ? 3'h7 : 3'h0);
      rdChk(8'h04, 32'h02, "main flags");
      rdChk(8'h0C, 32'hC3, "third flags");
      req(1'h0, 1'h0);
      wr(8'h04, 8'h00);
      wr(8'h0C, 8'hC0);
      pins(s ? 3'h0 : 3'h7);
      rdChk(8'h04, 32'h00, "main flags");
      rdChk(8'h0C, 32'hC0, "third flags");
    end
  endtask
  task testPriority;
    wr(8'h00, 8'h80);
    wr(8'h0C, 8'h08);
    wr(8'h04, 8'hC0);
    pins(3'h5);
    req(1'h0, 1'h1);
    rdChk(8'h24, 32'h2468, "return");
    rdChk(8'h20, 32'h000F3C5A, "shadow");
    wr(8'h0C, 8'h00);
    wr(8'h0C, 8'h48);
    pins(3'h7);
    pins(3'h5);
    req(1'h1, 1'h0);
    wr(8'h0C, 8'h40);
    settle;
    req(1'h0, 1'h0);
    wr(8'h04, 8'hD0);
    pins(3'h4);
    req(1'h1, 1'h0);
    wr(8'h04, 8'h00);
  endtask
  task testTimer;
    wr(8'h10, 8'hFC);
    wr(8'h1C, 8'h02);
    settle;
    rdChk(8'h04, 32'h04, "timer flag");
    wr(8'h08, 8'h04);
    wr(8'h04, 8'hA4);
    settle;
    req(1'h1, 1'h0);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'hE4);
    settle;
    req(1'h0, 1'h1);
    for (int h = 0; h < 2; h++)
    begin
      wr(8'h1C, 8'h00);
      wr(8'h14, h ? 8'hFF : 8'h00);
      wr(8'h10, 8'hF8);
      wr(8'h04, 8'h00);
      wr(8'h1C, 8'h03);
      settle;
      settle;
      rdChk(8'h04, h ? 32'h04 : 32'h00, "wide flag");
    end
    wr(8'h1C, 8'h00);
    wr(8'h04, 8'h00);
  endtask
  task testPort;
    wr(8'h00, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h04, 8'h00);
    @(posedge clk);
    portPin <= 8'h20;
    settle;
    rdChk(8'h04, 32'h01, "port flag");
    wr(8'h04, 8'hC9);
    settle;
    req(1'h1, 1'h0);
    wr(8'h04, 8'h89);
    settle;
    req(1'h0, 1'h0);
    xfer(8'h18, 1'h0, 8'h00);
    wr(8'h04, 8'h00);
    settle;
    rdChk(8'h04, 32'h00, "port flag");
    @(posedge clk);
    portIn <= 4'hD;
    portPin <= 8'h00;
    settle;
    rdChk(8'h04, 32'h00, "port flag");
  endtask
  task testWake;
    wr(8'h08, 8'h40);
    wr(8'h04, 8'h10);
    @(posedge clk);
    sleeping <= 1'h1;
    pins(3'h5);
    check("wakeUp", 32'(wakeUp), 32'h1);
    check("vector", 32'(vecWake), 32'h0);
    wr(8'h04, 8'h92);
    settle;
    check("vector", 32'(vecWake), 32'h1);
    @(posedge clk);
    sleeping <= 1'h0;
  endtask

  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    testCause;
    testEdges;
    testPriority;
    testTimer;
    testPort;
    testWake;
    results;
  end
endmodule // irq_sources_and_reset_flags_test

`default_nettype wire
